// file: rtl/usbpc_line_filter.sv
// line state change filter with a programmable log-2 delay
`timescale 1ns/100ps
module usbpc_line_filter (
  input  wire logic       core_clk,   // module clock
  input  wire logic       rst_b,      // async reset, active low
  input  wire logic       clkEn,      // freezes state while low
  input  wire logic [3:0] log2Delay,  // log-2 of delay in clocks
  input  wire logic [1:0] lineRaw,    // raw line state
  output logic      [1:0] lineFilt    // filtered line state
);
  // ----------------------------------------------------------------------
  // delay counter
  // ----------------------------------------------------------------------
  logic [1:0]  cand_r;
  logic [15:0] cnt_r;
  logic [15:0] target;
  logic        changed;

  // count of stable cycles needed: two to the programmed power
  assign target  = usbpc_pkg::CNT_ONE << log2Delay;
  assign changed = (lineRaw != cand_r);

  // a change must persist target cycles before it propagates
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      cand_r   <= usbpc_pkg::LS_J;
      cnt_r    <= '0;
      lineFilt <= usbpc_pkg::LS_J;
    end else if (clkEn) begin
      if (changed) begin
        cand_r <= lineRaw;
        cnt_r  <= usbpc_pkg::CNT_ONE;
        if (target == usbpc_pkg::CNT_ONE) begin
          lineFilt <= lineRaw;
        end
      end else if (cnt_r < target) begin
        cnt_r <= cnt_r + usbpc_pkg::CNT_ONE;
        if (cnt_r + usbpc_pkg::CNT_ONE == target) begin
          lineFilt <= cand_r;
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  one_cycle_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    (clkEn && log2Delay == 4'h0 && lineRaw != cand_r) |=> lineFilt == $past(lineRaw))
    else $error("zero setting must pass a change after one cycle");
  short_glitch_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    (clkEn && log2Delay != 4'h0 && changed && lineRaw != lineFilt) ##1
    (clkEn && lineRaw != cand_r) |=> $stable(lineFilt))
    else $error("a one-cycle glitch leaked through the filter");
endmodule

// file: rtl/usbpc_pkg.sv
// package: register map, field positions and reset values of the usb phy control block
package usbpc_pkg;
  // ----------------------------------------------------------------------
  // register offsets (byte addresses)
  // ----------------------------------------------------------------------
  localparam logic [7:0] POWER_SIG_OFF = 8'h3c;
  localparam logic [7:0] PHY_CTRL_OFF  = 8'h40;
  localparam int         ADDR_W        = 8;

  // ----------------------------------------------------------------------
  // power signalling fields
  // ----------------------------------------------------------------------
  localparam int         PWR_VALID_BIT = 8;
  localparam int         PWR_DATA_LSB  = 0;
  localparam int         PWR_DATA_W    = 8;
  localparam logic [8:0] PWR_RESET     = 9'h000;

  // ----------------------------------------------------------------------
  // phy control fields
  // ----------------------------------------------------------------------
  localparam int         PD_DIS_BIT    = 18;
  localparam int         SE0_SEEN_BIT  = 13;
  localparam int         K_SEEN_BIT    = 12;
  localparam int         FILT_LSB      = 8;
  localparam int         FILT_W        = 4;
  localparam int         AUTO_RES_BIT  = 7;
  localparam int         CONF_LSB      = 4;
  localparam int         CONF_W        = 3;
  localparam logic [3:0] FILT_RESET    = 4'h0;
  localparam logic [2:0] CONF_RESET    = 3'h0;

  // ----------------------------------------------------------------------
  // line state encodings and timing
  // ----------------------------------------------------------------------
  localparam logic [1:0] LS_SE0        = 2'h0;
  localparam logic [1:0] LS_J          = 2'h1;
  localparam logic [1:0] LS_K          = 2'h2;
  localparam int         CNT_W         = 16;
  localparam logic [15:0] CNT_ONE      = 16'h0001;
endpackage

// file: rtl/usbpc_regs.sv
// usb phy control and power signalling registers with avalon-mm slave
//
// Local design decision: the Avalon-MM slave port.
`timescale 1ns/100ps
module usbpc_regs (
  input  wire logic        core_clk,        // module clock, 250 MHz
  input  wire logic        rst_b,           // async reset, active low
  input  wire logic        clkEn,           // freezes all state while low
  input  wire logic [7:0]  avsAddress,      // avalon byte address
  input  wire logic        avsRead,         // avalon read
  input  wire logic        avsWrite,        // avalon write
  input  wire logic [31:0] avsWritedata,    // avalon write data
  input  wire logic [3:0]  avsByteenable,   // avalon byte enables
  output logic      [31:0] avsReaddata,     // avalon read data
  output logic             avsWaitrequest,  // avalon wait request
  output logic      [1:0]  avsResponse,     // 00 okay, 10 slave error
  input  wire logic        suspended,       // suspend controller in suspend
  input  wire logic [1:0]  lineState,       // raw phy line state
  output logic      [1:0]  lineStateFilt,   // filtered line state
  output logic             autoResume,      // pulse: hardware resume taken
  output logic      [2:0]  phyConfigPins,   // phy configuration pins
  output logic             pullDownDis,     // disable pull-downs on 8A/8B
  output logic      [7:0]  pwrData,         // power signalling data
  output logic             pwrValid         // power signalling valid
);
  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  typedef enum logic [0:0] {IDLE, ANSWER} usbpc_bus_type;
  usbpc_bus_type busState_r;
  logic [3:0]  filtLog2_r;
  logic        autoResEn_r;
  logic        se0Seen_r;
  logic        kSeen_r;
  logic [1:0]  lineFilt;
  logic [1:0]  lineFiltPrev_r;

  // ----------------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------------
  logic        access;
  logic        hitPwr;
  logic        hitCtrl;
  logic        wrPwr;
  logic        wrCtrl;
  logic [31:0] pwrWord;
  logic [31:0] ctrlWord;
  logic [31:0] readMux;
  logic        resumeEvt;
  logic        resumeSe0;
  logic        resumeK;
  logic        clrSe0;
  logic        clrK;

  assign access  = (avsRead || avsWrite) && (busState_r == IDLE);
  assign hitPwr  = (avsAddress == usbpc_pkg::POWER_SIG_OFF);
  assign hitCtrl = (avsAddress == usbpc_pkg::PHY_CTRL_OFF);
  assign wrPwr   = access && avsWrite && hitPwr;
  assign wrCtrl  = access && avsWrite && hitCtrl;

  // reserved bits stay zero in the read words
  assign pwrWord  = {23'h000000, pwrValid, pwrData};
  assign ctrlWord = {13'h0000, pullDownDis, 4'h0, se0Seen_r, kSeen_r, filtLog2_r,
                     autoResEn_r, phyConfigPins, 4'h0};
  assign readMux  = hitPwr ? pwrWord : (hitCtrl ? ctrlWord : 32'h00000000);

  // ----------------------------------------------------------------------
  // resume detection
  // ----------------------------------------------------------------------
  // hardware resume only when enabled, on the filtered line leaving idle
  assign resumeEvt = autoResEn_r && suspended && (lineFilt != lineFiltPrev_r)
                     && (lineFilt != usbpc_pkg::LS_J);
  assign resumeSe0 = resumeEvt && (lineFilt == usbpc_pkg::LS_SE0);
  assign resumeK   = resumeEvt && (lineFilt == usbpc_pkg::LS_K);
  // a written zero clears the flag, only with its byte enabled
  assign clrSe0 = wrCtrl && avsByteenable[1] && !avsWritedata[usbpc_pkg::SE0_SEEN_BIT];
  assign clrK   = wrCtrl && avsByteenable[1] && !avsWritedata[usbpc_pkg::K_SEEN_BIT];

  // ----------------------------------------------------------------------
  // line filter
  // ----------------------------------------------------------------------
  usbpc_line_filter u_filter (
    .core_clk  (core_clk),
    .rst_b     (rst_b),
    .clkEn     (clkEn),
    .log2Delay (filtLog2_r),
    .lineRaw   (lineState),
    .lineFilt  (lineFilt)
  );

  // ----------------------------------------------------------------------
  // bus handshake: one wait cycle, answer in the next
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      busState_r     <= IDLE;
      avsWaitrequest <= 1'b1;
      avsReaddata    <= 32'h00000000;
      avsResponse    <= 2'h0;
    end else if (clkEn) begin
      unique case (busState_r)
        IDLE: begin
          if (access) begin
            busState_r     <= ANSWER;
            avsWaitrequest <= 1'b0;
            avsReaddata    <= avsRead ? readMux : 32'h00000000;
            avsResponse    <= (hitPwr || hitCtrl) ? 2'h0 : 2'h2;
          end
        end
        ANSWER: begin
          busState_r     <= IDLE;
          avsWaitrequest <= 1'b1;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // power signalling register
  // ----------------------------------------------------------------------
  // data and valid stored as written, byte lanes honoured
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      pwrData  <= usbpc_pkg::PWR_RESET[7:0];
      pwrValid <= usbpc_pkg::PWR_RESET[8];
    end else if (clkEn && wrPwr) begin
      if (avsByteenable[0]) pwrData <= avsWritedata[7:0];
      if (avsByteenable[1]) pwrValid <= avsWritedata[usbpc_pkg::PWR_VALID_BIT];
    end
  end

  // ----------------------------------------------------------------------
  // phy control: software fields
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      pullDownDis   <= 1'b0;
      filtLog2_r    <= usbpc_pkg::FILT_RESET;
      autoResEn_r   <= 1'b0;
      phyConfigPins <= usbpc_pkg::CONF_RESET;
    end else if (clkEn && wrCtrl) begin
      if (avsByteenable[2]) pullDownDis <= avsWritedata[usbpc_pkg::PD_DIS_BIT];
      if (avsByteenable[1]) filtLog2_r <= avsWritedata[11:8];
      if (avsByteenable[0]) begin
        autoResEn_r   <= avsWritedata[usbpc_pkg::AUTO_RES_BIT];
        phyConfigPins <= avsWritedata[6:4];
      end
    end
  end

  // ----------------------------------------------------------------------
  // phy control: resume cause flags, set wins over clear
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      se0Seen_r      <= 1'b0;
      kSeen_r        <= 1'b0;
      lineFiltPrev_r <= usbpc_pkg::LS_J;
      autoResume     <= 1'b0;
      lineStateFilt  <= usbpc_pkg::LS_J;
    end else if (clkEn) begin
      lineFiltPrev_r <= lineFilt;
      lineStateFilt  <= lineFilt;
      autoResume     <= resumeEvt;
      if (resumeSe0) se0Seen_r <= 1'b1;
      else if (clrSe0) se0Seen_r <= 1'b0;
      if (resumeK) kSeen_r <= 1'b1;
      else if (clrK) kSeen_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  pulldown_follows_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    (clkEn && wrCtrl && avsByteenable[2]) |=> pullDownDis == $past(avsWritedata[18]))
    else $error("pull-down disable did not follow the write");
  se0_flag_set_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    (clkEn && resumeSe0) |=> se0Seen_r)
    else $error("se0 resume did not set its flag");
  se0_flag_hold_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    (se0Seen_r && !(clkEn && clrSe0)) |=> se0Seen_r)
    else $error("se0 flag dropped without a clear");
  k_flag_set_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    (clkEn && resumeK) |=> kSeen_r)
    else $error("k resume did not set its flag");
  k_flag_hold_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    (kSeen_r && !(clkEn && clrK)) |=> kSeen_r)
    else $error("k flag dropped without a clear");
  no_auto_resume_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    (!autoResEn_r || !suspended) |=> !autoResume)
    else $error("auto resume fired while disabled");
  conf_pins_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    (clkEn && wrCtrl && avsByteenable[0]) |=> phyConfigPins == $past(avsWritedata[6:4]))
    else $error("configuration pins did not follow the write");
  reserved_zero_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    (!avsWaitrequest && hitCtrl && avsRead) |-> (avsReaddata & 32'hfffbc00f) == 32'h0)
    else $error("reserved control bits read nonzero");
  pwr_store_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    (clkEn && wrPwr && avsByteenable[0]) |=> pwrData == $past(avsWritedata[7:0]))
    else $error("power data not stored as written");
  bus_answer_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    (clkEn && access) |=> !avsWaitrequest ##1 avsWaitrequest)
    else $error("bus answer not exactly one cycle");

  // filtered line and resume pulse are registered copies
  lsfilt_follows_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    clkEn
    |=> lineStateFilt == $past(lineFilt))
    else $error("filtered line output lost its source");
  auto_pulse_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    clkEn
    |=> autoResume == $past(resumeEvt))
    else $error("resume pulse does not match its event");

  // flags clear on a written zero and rise only on their own cause
  se0_flag_clear_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    (clkEn && clrSe0 && !resumeSe0)
    |=> !se0Seen_r)
    else $error("se0 flag survived a written zero");
  k_flag_clear_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    (clkEn && clrK && !resumeK)
    |=> !kSeen_r)
    else $error("k flag survived a written zero");
  se0_flag_rise_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    (!se0Seen_r && !(clkEn && resumeSe0))
    |=> !se0Seen_r)
    else $error("se0 flag rose without an se0 resume");
  k_flag_rise_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    (!kSeen_r && !(clkEn && resumeK))
    |=> !kSeen_r)
    else $error("k flag rose without a k resume");

  // software fields take the written value on their lanes
  filt_follows_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    (clkEn && wrCtrl && avsByteenable[1])
    |=> filtLog2_r == $past(avsWritedata[11:8]))
    else $error("filter setting did not follow the write");
  auto_en_follows_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    (clkEn && wrCtrl && avsByteenable[0])
    |=> autoResEn_r == $past(avsWritedata[7]))
    else $error("resume enable did not follow the write");
  pwr_valid_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    (clkEn && wrPwr && avsByteenable[1])
    |=> pwrValid == $past(avsWritedata[8]))
    else $error("power valid not stored as written");

  // read words mirror the stored fields, reserved bits zero
  ctrl_read_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    (!avsWaitrequest && hitCtrl && avsRead)
    |-> avsReaddata[6:4] == phyConfigPins && avsReaddata[18] == pullDownDis)
    else $error("control read does not show the pin fields");
  pwr_read_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    (!avsWaitrequest && hitPwr && avsRead)
    |-> avsReaddata[8:0] == {pwrValid, pwrData})
    else $error("power read does not show the stored word");
  pwr_reserved_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    (!avsWaitrequest && hitPwr && avsRead)
    |-> avsReaddata[31:9] == 23'h000000)
    else $error("reserved power bits read nonzero");

  // a low clock enable freezes state
  freeze_pins_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    !clkEn
    |=> $stable(phyConfigPins) && $stable(pullDownDis) && $stable(avsWaitrequest))
    else $error("pins moved while the clock enable was low");
  freeze_flags_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    !clkEn
    |=> $stable(se0Seen_r) && $stable(kSeen_r) && $stable(lineStateFilt))
    else $error("flags moved while the clock enable was low");

  // unmapped addresses answer with an error and change nothing
  unmapped_resp_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    (clkEn && access && !hitPwr && !hitCtrl)
    |=> avsResponse == 2'h2)
    else $error("unmapped access not answered with an error");
  unmapped_keep_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    (clkEn && access && avsWrite && !hitPwr && !hitCtrl)
    |=> $stable(pwrData) && $stable(pwrValid) && $stable(pullDownDis) && $stable(phyConfigPins))
    else $error("unmapped write changed a register");

  // writes answer with zero data; an idle bus holds wait
  write_data_zero_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    (clkEn && access && avsWrite)
    |=> avsReaddata == 32'h00000000)
    else $error("write answered with nonzero read data");
  idle_wait_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    (busState_r == IDLE)
    |-> avsWaitrequest)
    else $error("wait request low while the bus is idle");

  se0_resume_c: cover property (@(posedge core_clk) disable iff (!rst_b) resumeSe0);
  k_resume_c:   cover property (@(posedge core_clk) disable iff (!rst_b) resumeK);
  set_clear_c:  cover property (@(posedge core_clk) disable iff (!rst_b) resumeK && clrK);
  bad_addr_c:   cover property (@(posedge core_clk) disable iff (!rst_b) avsResponse == 2'h2);
  se0_clear_c:  cover property (@(posedge core_clk) disable iff (!rst_b) se0Seen_r && clrSe0);
endmodule

// file: sim/testbench.sv
// self-checking bench for the usb phy control registers
`timescale 1ns/100ps
module testbench;
  logic        core_clk;        // module clock
  logic        rst_b;           // reset, active low
  logic [7:0]  avsAddress;      // bus address
  logic        avsRead;         // bus read
  logic        avsWrite;        // bus write
  logic [31:0] avsWritedata;    // bus write data
  logic [3:0]  avsByteenable;   // bus lanes
  logic [31:0] avsReaddata;     // bus read data
  logic        avsWaitrequest;  // bus wait
  logic [1:0]  avsResponse;     // bus response
  logic        suspended;       // suspend state
  logic [1:0]  lineState;       // raw line
  logic [1:0]  lineStateFilt;   // filtered line
  logic        autoResume;      // resume pulse
  logic [2:0]  phyConfigPins;   // config pins
  logic        pullDownDis;     // pull-down disable
  logic [7:0]  pwrData;         // power data
  logic        pwrValid;        // power valid
  logic [1:0]  cmdLine;         // line command
  logic        cmdSusp;         // suspend command
  logic        clkEn;           // clock enable
  int          n_errors;
  int          check_count;
  int          cycles;
  int          resumes;

  usbpc_regs usbpc_regs_inst (.core_clk(core_clk), .rst_b(rst_b), .clkEn(clkEn),
    .avsAddress(avsAddress), .avsRead(avsRead), .avsWrite(avsWrite),
    .avsWritedata(avsWritedata), .avsByteenable(avsByteenable),
    .avsReaddata(avsReaddata), .avsWaitrequest(avsWaitrequest),
    .avsResponse(avsResponse), .suspended(suspended), .lineState(lineState),
    .lineStateFilt(lineStateFilt), .autoResume(autoResume),
    .phyConfigPins(phyConfigPins), .pullDownDis(pullDownDis),
    .pwrData(pwrData), .pwrValid(pwrValid));
  usbpc_phy_model usbpc_phy_model_inst (.core_clk(core_clk), .rst_b(rst_b),
    .cmdLine(cmdLine), .cmdSusp(cmdSusp), .phyConfigPins(phyConfigPins),
    .pullDownDis(pullDownDis), .lineState(lineState), .suspended(suspended));

  // ----------------------------------------------------------------------
  // clock, timeout and resume pulse counter
  // ----------------------------------------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cycles++;
    if (autoResume === 1'b1) resumes++;
    if (cycles == 5000) begin
      n_errors++;
      close_out();
    end
  end

  task automatic close_out();
    $display("errors %0d checks %0d", n_errors, check_count);
    if (n_errors == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t word got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cmp_resp(input logic [1:0] got, input logic [1:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t response got %h exp %h", $time, got, exp);
    end
  endtask

  // one bus access: hold until waitrequest is seen low, take the answer there
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] be, output logic [31:0] rd, output logic [1:0] rs);
    int n;
    n = 0;
    @(posedge core_clk);
    avsAddress    <= a;
    avsWritedata  <= d;
    avsByteenable <= be;
    avsWrite      <= wr;
    avsRead       <= !wr;
    do begin
      @(posedge core_clk);
      n++;
    end while (avsWaitrequest !== 1'b0 && n < 50);
    rd = avsReaddata;
    rs = avsResponse;
    avsWrite <= 1'b0;
    avsRead  <= 1'b0;
    if (n >= 50) cmp_word(32'h0, 32'h1);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] be,
                    input logic [1:0] exs);
    logic [31:0] rd;
    logic [1:0]  rs;
    bus(1'b1, a, d, be, rd, rs);
    cmp_resp(rs, exs);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] exs);
    logic [31:0] d;
    logic [1:0]  rs;
    bus(1'b0, a, 32'h0, 4'hf, d, rs);
    cmp_word(d, exp);
    cmp_resp(rs, exs);
  endtask
  task automatic line(input logic [1:0] ls, input int wait_n);
    cmdLine <= ls;
    repeat (wait_n) @(posedge core_clk);
  endtask

  // ----------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------
  initial begin
    rst_b = 1'b0; avsAddress = 8'h00; avsRead = 1'b0; avsWrite = 1'b0;
    avsWritedata = 32'h0; avsByteenable = 4'h0; cmdLine = usbpc_pkg::LS_J;
    cmdSusp = 1'b0; n_errors = 0; check_count = 0; cycles = 0; resumes = 0;
    clkEn = 1'b1;
    repeat (12) @(posedge core_clk);
    rst_b <= 1'b1;
    rd(usbpc_pkg::POWER_SIG_OFF, 32'h0, 2'h0);
    rd(usbpc_pkg::PHY_CTRL_OFF, 32'h0, 2'h0);
    cmp_word({30'h0, lineStateFilt}, 32'h1);
    wr(usbpc_pkg::POWER_SIG_OFF, 32'hffffffff, 4'hf, 2'h0);
    rd(usbpc_pkg::POWER_SIG_OFF, 32'h1ff, 2'h0);
    wr(usbpc_pkg::POWER_SIG_OFF, 32'h0, 4'h2, 2'h0);
    rd(usbpc_pkg::POWER_SIG_OFF, 32'hff, 2'h0);
    cmp_word({23'h0, pwrValid, pwrData}, 32'hff);
    wr(usbpc_pkg::PHY_CTRL_OFF, 32'hffffffff, 4'hf, 2'h0);
    rd(usbpc_pkg::PHY_CTRL_OFF, 32'h40ff0, 2'h0);
    cmp_word({31'h0, pullDownDis}, 32'h1);
    for (int c = 0; c < 8; c++) begin
      wr(usbpc_pkg::PHY_CTRL_OFF, c << 4, 4'h1, 2'h0);
      cmp_word({29'h0, phyConfigPins}, c);
    end
    wr(usbpc_pkg::PHY_CTRL_OFF, 32'h0, 4'h4, 2'h0);
    cmp_word({31'h0, pullDownDis}, 32'h0);
    wr(8'h44, 32'hffffffff, 4'hf, 2'h2);
    rd(8'h44, 32'h0, 2'h2);
    // filter with a delay of eight clocks: a seven clock glitch is dropped
    wr(usbpc_pkg::PHY_CTRL_OFF, 32'h300, 4'h2, 2'h0);
    line(usbpc_pkg::LS_K, 7);
    line(usbpc_pkg::LS_J, 15);
    cmp_word({30'h0, lineStateFilt}, 32'h1);
    line(usbpc_pkg::LS_K, 7);
    cmp_word({30'h0, lineStateFilt}, 32'h1);
    repeat (6) @(posedge core_clk);
    cmp_word({30'h0, lineStateFilt}, 32'h2);
    line(usbpc_pkg::LS_J, 14);
    // a one clock glitch is dropped as well
    line(usbpc_pkg::LS_K, 1);
    line(usbpc_pkg::LS_J, 14);
    cmp_word({30'h0, lineStateFilt}, 32'h1);
    // hardware resume from se0 and from k while suspended
    wr(usbpc_pkg::PHY_CTRL_OFF, 32'h80, 4'h3, 2'h0);
    cmdSusp <= 1'b1;
    line(usbpc_pkg::LS_SE0, 6);
    cmp_word(resumes, 32'h1);
    rd(usbpc_pkg::PHY_CTRL_OFF, 32'h2080, 2'h0);
    wr(usbpc_pkg::PHY_CTRL_OFF, 32'h0, 4'h2, 2'h0);
    rd(usbpc_pkg::PHY_CTRL_OFF, 32'h80, 2'h0);
    line(usbpc_pkg::LS_J, 4);
    line(usbpc_pkg::LS_K, 6);
    cmp_word(resumes, 32'h2);
    wr(usbpc_pkg::PHY_CTRL_OFF, 32'h1000, 4'h2, 2'h0);
    rd(usbpc_pkg::PHY_CTRL_OFF, 32'h1080, 2'h0);
    wr(usbpc_pkg::PHY_CTRL_OFF, 32'h0, 4'h3, 2'h0);
    rd(usbpc_pkg::PHY_CTRL_OFF, 32'h0, 2'h0);
    // resume handling off: line changes leave flags and pulse alone
    line(usbpc_pkg::LS_J, 4);
    line(usbpc_pkg::LS_SE0, 6);
    rd(usbpc_pkg::PHY_CTRL_OFF, 32'h0, 2'h0);
    cmp_word(resumes, 32'h2);
    cmp_word({30'h0, lineStateFilt}, 32'h0);
    cmdSusp <= 1'b0;
    // clock enable low freezes the filtered line, high lets it move on
    clkEn <= 1'b0;
    line(usbpc_pkg::LS_J, 4);
    cmp_word({30'h0, lineStateFilt}, 32'h0);
    clkEn <= 1'b1;
    line(usbpc_pkg::LS_J, 4);
    cmp_word({30'h0, lineStateFilt}, 32'h1);
    close_out();
  end
endmodule

// file: sim/usbpc_phy_model.sv
// behavioural phy and suspend controller model driving the line side of the block
`timescale 1ns/100ps
module usbpc_phy_model (
  input  wire logic       core_clk,       // module clock
  input  wire logic       rst_b,          // async reset, active low
  input  wire logic [1:0] cmdLine,        // line state asked for by the bench
  input  wire logic       cmdSusp,        // suspend state asked for by the bench
  input  wire logic [2:0] phyConfigPins,  // configuration pins from the block
  input  wire logic       pullDownDis,    // pull-down disable from the block
  output logic      [1:0] lineState,      // raw line state to the block
  output logic            suspended       // suspend controller state
);
  logic [2:0] seenConf_r;  // last configuration seen on the pins while pull-downs were disabled

  // ----------------------------------------------------------------------
  // line and suspend drivers, one cycle behind the bench's command
  // ----------------------------------------------------------------------
  // suspend and line events come from this side of the link
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      lineState  <= usbpc_pkg::LS_J;
      suspended  <= 1'b0;
      seenConf_r <= 3'h0;
    end else begin
      lineState  <= cmdLine;
      suspended  <= cmdSusp;
      seenConf_r <= pullDownDis ? phyConfigPins : seenConf_r;
    end
  end
endmodule
